// >>> include/lux_alert_pkg.sv
// Shared constants and carrier types of the lux result and threshold alert block.
package lux_alert_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_ALERT_STATUS = 8'h00;
   localparam logic [7:0] ADDR_ALERT_ENABLE = 8'h01;
   localparam logic [7:0] ADDR_CONFIG = 8'h02;
   localparam logic [7:0] ADDR_LUX_RESULT_HIGH = 8'h03;
   localparam logic [7:0] ADDR_LUX_RESULT_LOW = 8'h04;
   localparam logic [7:0] ADDR_UPPER_TRIP_LEVEL = 8'h05;
   localparam logic [7:0] ADDR_LOWER_TRIP_LEVEL = 8'h06;
   localparam logic [7:0] ADDR_TRIP_PERSISTENCE_TIME = 8'h07;

   // ----------------------------------------------------------------
   // Field positions and values after reset
   // ----------------------------------------------------------------
   localparam int CFG_CONT_BIT = 7;
   localparam int CFG_MANUAL_BIT = 6;
   localparam int CFG_CDR_BIT = 3;
   localparam logic [7:0] RST_UPPER_TRIP = 8'hff;
   localparam logic [7:0] RST_LOWER_TRIP = 8'h00;
   localparam logic [7:0] RST_PERSISTENCE = 8'hff;
   localparam logic [3:0] EXP_OVERRANGE = 4'hf;
   localparam logic [3:0] UPPER_MANT_FILL = 4'hf;
   localparam logic [3:0] LOWER_MANT_FILL = 4'h0;

   // ----------------------------------------------------------------
   // Integration period selector codes and their periods in microseconds
   // ----------------------------------------------------------------
   localparam logic [2:0] TIM_800 = 3'h0;
   localparam logic [2:0] TIM_400 = 3'h1;
   localparam logic [2:0] TIM_200 = 3'h2;
   localparam logic [2:0] TIM_100 = 3'h3;
   localparam logic [2:0] TIM_50 = 3'h4;
   localparam logic [2:0] TIM_25 = 3'h5;
   localparam logic [2:0] TIM_12P5 = 3'h6;
   localparam logic [2:0] TIM_6P25 = 3'h7;
   localparam logic [19:0] PERIOD_US_800 = 20'hc3500;
   localparam logic [19:0] PERIOD_US_400 = 20'h61a80;
   localparam logic [19:0] PERIOD_US_200 = 20'h30d40;
   localparam logic [19:0] PERIOD_US_100 = 20'h186a0;
   localparam logic [19:0] PERIOD_US_50 = 20'h0c350;
   localparam logic [19:0] PERIOD_US_25 = 20'h061a8;
   localparam logic [19:0] PERIOD_US_12P5 = 20'h030d4;
   localparam logic [19:0] PERIOD_US_6P25 = 20'h0186a;

   // Autoranging limits in counts of 0.025 lux (700 lux is 28000 counts).
   localparam logic [22:0] AUTO_DIVIDE_ABOVE = 23'h006d60;
   localparam logic [22:0] AUTO_800_BELOW = 23'h001000;
   localparam logic [22:0] AUTO_400_BELOW = 23'h002000;
   localparam logic [22:0] AUTO_200_BELOW = 23'h004000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 50000000;
   localparam int PERSIST_STEP_MS = 100;
   localparam int PERSIST_STEP_CYCLES = (CLK_HZ / 1000) * PERSIST_STEP_MS;

   // ----------------------------------------------------------------
   // Carriers and state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic valid;
      logic [3:0] exponent;
      logic [7:0] mantissa;
   } conv_result_t;

   typedef struct packed {
      logic [31:0] step_cnt;
      logic [7:0] step_num;
   } persist_state_t;

   typedef struct packed {
      logic [7:0] upper_trip_level;
      logic [7:0] lower_trip_level;
      logic [7:0] trip_persistence_time;
      logic alert_enable_bit;
      logic alert_status_bit;
      logic cont;
      logic manual;
      logic cdr_user;
      logic [2:0] tim_user;
      logic cdr_auto;
      logic [2:0] tim_auto;
      logic [3:0] live_exp;
      logic [7:0] live_mant;
      logic [7:0] lux_result_high;
      logic [7:0] lux_result_low;
      logic frozen;
      logic scl_prev;
      logic sda_prev;
      logic [7:0] rdata;
   } lux_state_t;

endpackage

// >>> rtl/pin_sync.sv
// Two flip-flop synchroniser for pins from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } sync_state_t;

   sync_state_t st_reg;
   sync_state_t st_next;

   always_comb
   begin
      st_next = st_reg;
      if (i_ce)
      begin
         st_next.stage1 = i_async;
         st_next.stage2 = st_reg.stage1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         st_reg <= '1;
      else
         st_reg <= st_next;
   end

   assign o_sync = st_reg.stage2;
endmodule
`default_nettype wire

// >>> rtl/persistence_timer.sv
// Persistence timer that measures how long a threshold crossing lasts.
`timescale 1ns/1ps
`default_nettype none
module persistence_timer
   import lux_alert_pkg::*;
#(
   parameter int STEP_CYCLES = lux_alert_pkg::PERSIST_STEP_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_outside,
   input wire logic [7:0] i_limit,
   output logic o_expired
);
   import lux_alert_pkg::*;

   persist_state_t st_reg;
   persist_state_t st_next;

   // The step count saturates at the limit, so a crossing that outlasts it keeps the output high.
   assign o_expired = i_outside && (st_reg.step_num == i_limit);

   always_comb
   begin
      st_next = st_reg;
      if (i_ce)
      begin
         if (!i_outside)
         begin
            st_next = '0;
         end
         else if (st_reg.step_num != i_limit)
         begin
            if (st_reg.step_cnt == 32'(STEP_CYCLES - 1))
            begin
               st_next.step_cnt = '0;
               st_next.step_num = st_reg.step_num + 8'h01;
            end
            else
               st_next.step_cnt = st_reg.step_cnt + 32'h1;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end
endmodule
`default_nettype wire

// >>> rtl/lux_result_threshold_alert.sv
// Lux result registers, autoranging and threshold alert of the light sensor.
`timescale 1ns/1ps
`default_nettype none
module lux_result_threshold_alert
   import lux_alert_pkg::*;
#(
   parameter int PERSIST_CYCLES = lux_alert_pkg::PERSIST_STEP_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire lux_alert_pkg::reg_req_t i_reg_req,
   output logic [7:0] o_reg_rdata,
   input wire lux_alert_pkg::conv_result_t i_conv,
   output logic [2:0] o_integ_period_sel,
   output logic [19:0] o_integ_period_us,
   output logic o_current_divide_sel,
   output logic o_continuous,
   output logic o_alert_n_out,
   output logic o_alert_n_oe
);
   import lux_alert_pkg::*;

   // ----------------------------------------------------------------
   // Bus pins and frame detection
   // ----------------------------------------------------------------
   logic [1:0] pins_sync;
   logic scl_s;
   logic sda_s;
   logic bus_start;
   logic bus_stop;

   pin_sync #(
      .W(2)
   ) u_pin_sync (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_async({i_scl, i_sda}),
      .o_sync(pins_sync)
   );

   assign scl_s = pins_sync[1];
   assign sda_s = pins_sync[0];

   lux_state_t st_reg;
   lux_state_t st_next;

   // A start (also a repeated one) opens the freeze; only a stop ends it.
   assign bus_start = scl_s && st_reg.scl_prev && st_reg.sda_prev && !sda_s;
   assign bus_stop = scl_s && st_reg.scl_prev && !st_reg.sda_prev && sda_s;

   // ----------------------------------------------------------------
   // Lux levels in counts of 0.025 lux
   // ----------------------------------------------------------------
   function automatic logic [22:0] lux_counts(input logic [3:0] e, input logic [7:0] m);
      logic [22:0] wide;
      wide = {15'h0000, m};
      lux_counts = wide << e;
   endfunction

   logic [22:0] live_counts;
   logic [22:0] upper_counts;
   logic [22:0] lower_counts;
   logic overrange;
   logic above_upper;
   logic below_lower;
   logic persist_expired;

   assign overrange = (st_reg.live_exp == EXP_OVERRANGE);
   assign live_counts = lux_counts(st_reg.live_exp, st_reg.live_mant);
   assign upper_counts = lux_counts(st_reg.upper_trip_level[7:4],
                                    {st_reg.upper_trip_level[3:0], UPPER_MANT_FILL});
   assign lower_counts = lux_counts(st_reg.lower_trip_level[7:4],
                                    {st_reg.lower_trip_level[3:0], LOWER_MANT_FILL});
   assign above_upper = overrange || (live_counts > upper_counts);
   assign below_lower = !overrange && (live_counts < lower_counts);

   persistence_timer #(
      .STEP_CYCLES(PERSIST_CYCLES)
   ) u_persist (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_outside(above_upper || below_lower),
      .i_limit(st_reg.trip_persistence_time),
      .o_expired(persist_expired)
   );

   // ----------------------------------------------------------------
   // Autoranging choice from the newest conversion
   // ----------------------------------------------------------------
   logic [22:0] conv_counts;
   logic [2:0] tim_auto_pick;
   logic cdr_auto_pick;

   // An overrange reading counts as the brightest light, so autoranging picks the short period and the divider.
   assign conv_counts = (i_conv.exponent == EXP_OVERRANGE) ? '1 : lux_counts(i_conv.exponent, i_conv.mantissa);
   assign cdr_auto_pick = (conv_counts > AUTO_DIVIDE_ABOVE);

   always_comb
   begin
      if (conv_counts < AUTO_800_BELOW)
         tim_auto_pick = TIM_800;
      else if (conv_counts < AUTO_400_BELOW)
         tim_auto_pick = TIM_400;
      else if (conv_counts < AUTO_200_BELOW)
         tim_auto_pick = TIM_200;
      else
         tim_auto_pick = TIM_100;
   end

   // ----------------------------------------------------------------
   // Effective range and period decode
   // ----------------------------------------------------------------
   logic [2:0] tim_eff;
   logic cdr_eff;

   assign tim_eff = st_reg.manual ? st_reg.tim_user : st_reg.tim_auto;
   assign cdr_eff = st_reg.manual ? st_reg.cdr_user : st_reg.cdr_auto;

   always_comb
   begin
      unique case (tim_eff)
         TIM_800: o_integ_period_us = PERIOD_US_800;
         TIM_400: o_integ_period_us = PERIOD_US_400;
         TIM_200: o_integ_period_us = PERIOD_US_200;
         TIM_100: o_integ_period_us = PERIOD_US_100;
         TIM_50: o_integ_period_us = PERIOD_US_50;
         TIM_25: o_integ_period_us = PERIOD_US_25;
         TIM_12P5: o_integ_period_us = PERIOD_US_12P5;
         TIM_6P25: o_integ_period_us = PERIOD_US_6P25;
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic [7:0] config_rd;
   logic status_clear;

   always_comb
   begin
      config_rd = 8'h00;
      config_rd[CFG_CONT_BIT] = st_reg.cont;
      config_rd[CFG_MANUAL_BIT] = st_reg.manual;
      config_rd[CFG_CDR_BIT] = cdr_eff;
      config_rd[2:0] = tim_eff;
   end

   logic enable_written_zero;
   logic alert_event;

   assign enable_written_zero = i_reg_req.wr && i_reg_req.addr == ADDR_ALERT_ENABLE && !i_reg_req.wdata[0];
   assign status_clear = (i_reg_req.rd && i_reg_req.addr == ADDR_ALERT_STATUS) || enable_written_zero;
   // A disable in the same cycle beats a crossing, so a lasting crossing cannot set the status again.
   assign alert_event = st_reg.alert_enable_bit && !enable_written_zero && persist_expired;

   always_comb
   begin
      st_next = st_reg;
      if (i_ce)
      begin
         st_next.scl_prev = scl_s;
         st_next.sda_prev = sda_s;
         if (bus_stop)
            st_next.frozen = 1'b0;
         else if (bus_start)
            st_next.frozen = 1'b1;
         if (i_conv.valid)
         begin
            st_next.live_exp = i_conv.exponent;
            st_next.live_mant = i_conv.mantissa;
            if (!st_reg.manual)
            begin
               st_next.tim_auto = tim_auto_pick;
               st_next.cdr_auto = cdr_auto_pick;
            end
            if (!st_reg.frozen && !bus_start)
            begin
               st_next.lux_result_high = {i_conv.exponent, i_conv.mantissa[7:4]};
               st_next.lux_result_low = {4'h0, i_conv.mantissa[3:0]};
            end
         end
         if (i_reg_req.wr)
         begin
            unique case (i_reg_req.addr)
               ADDR_ALERT_ENABLE: st_next.alert_enable_bit = i_reg_req.wdata[0];
               ADDR_CONFIG:
               begin
                  st_next.cont = i_reg_req.wdata[CFG_CONT_BIT];
                  st_next.manual = i_reg_req.wdata[CFG_MANUAL_BIT];
                  if (st_reg.manual)
                  begin
                     st_next.cdr_user = i_reg_req.wdata[CFG_CDR_BIT];
                     st_next.tim_user = i_reg_req.wdata[2:0];
                  end
               end
               ADDR_UPPER_TRIP_LEVEL: st_next.upper_trip_level = i_reg_req.wdata;
               ADDR_LOWER_TRIP_LEVEL: st_next.lower_trip_level = i_reg_req.wdata;
               ADDR_TRIP_PERSISTENCE_TIME: st_next.trip_persistence_time = i_reg_req.wdata;
               default: ;
            endcase
         end
         if (i_reg_req.rd)
         begin
            unique case (i_reg_req.addr)
               ADDR_ALERT_STATUS: st_next.rdata = {7'h00, st_reg.alert_status_bit};
               ADDR_ALERT_ENABLE: st_next.rdata = {7'h00, st_reg.alert_enable_bit};
               ADDR_CONFIG: st_next.rdata = config_rd;
               ADDR_LUX_RESULT_HIGH: st_next.rdata = st_reg.lux_result_high;
               ADDR_LUX_RESULT_LOW: st_next.rdata = st_reg.lux_result_low;
               ADDR_UPPER_TRIP_LEVEL: st_next.rdata = st_reg.upper_trip_level;
               ADDR_LOWER_TRIP_LEVEL: st_next.rdata = st_reg.lower_trip_level;
               ADDR_TRIP_PERSISTENCE_TIME: st_next.rdata = st_reg.trip_persistence_time;
               default: st_next.rdata = 8'h00;
            endcase
         end
         // A new event in the clearing cycle wins, so no crossing is lost.
         if (status_clear)
            st_next.alert_status_bit = 1'b0;
         if (alert_event)
            st_next.alert_status_bit = 1'b1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         st_reg <= '0;
         st_reg.upper_trip_level <= RST_UPPER_TRIP;
         st_reg.lower_trip_level <= RST_LOWER_TRIP;
         st_reg.trip_persistence_time <= RST_PERSISTENCE;
         st_reg.tim_auto <= TIM_100;
         st_reg.scl_prev <= 1'b1;
         st_reg.sda_prev <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_reg_rdata = st_reg.rdata;
   assign o_integ_period_sel = tim_eff;
   assign o_current_divide_sel = cdr_eff;
   assign o_continuous = st_reg.cont;
   assign o_alert_n_out = 1'b0;
   assign o_alert_n_oe = st_reg.alert_status_bit;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   alert_pin_follows_a: assert property (o_alert_n_oe == st_reg.alert_status_bit && !o_alert_n_out)
      else $error("alert pin does not follow status");
   alert_needs_enable_a: assert property ($rose(st_reg.alert_status_bit) |-> $past(st_reg.alert_enable_bit))
      else $error("alert set without enable");
   // The alert checks keep the disable case apart, since a zero written to the enable beats a crossing.
   status_read_clears_a: assert property (i_ce && i_reg_req.rd && i_reg_req.addr == ADDR_ALERT_STATUS
      && !alert_event |=> !st_reg.alert_status_bit)
      else $error("status read did not clear");
   enable_off_clears_a: assert property (i_ce && enable_written_zero |=> !st_reg.alert_status_bit)
      else $error("enable write of zero did not clear");
   zero_timer_immediate_a: assert property (i_ce && st_reg.alert_enable_bit && !enable_written_zero
      && st_reg.trip_persistence_time == 8'h00 && (above_upper || below_lower) |=> st_reg.alert_status_bit)
      else $error("zero timer alert delayed");
   frozen_hold_a: assert property (st_reg.frozen && !bus_stop
      |=> $stable(st_reg.lux_result_high) && $stable(st_reg.lux_result_low))
      else $error("result changed while frozen");
   start_freezes_a: assert property (i_ce && bus_start |=> st_reg.frozen)
      else $error("start did not freeze results");
   stop_releases_a: assert property (i_ce && bus_stop |=> !st_reg.frozen)
      else $error("stop did not release results");
   auto_periods_a: assert property (!st_reg.manual |-> !tim_eff[2])
      else $error("auto range chose manual-only period");
   low_nibble_zero_a: assert property (st_reg.lux_result_low[7:4] == 4'h0)
      else $error("result low byte upper nibble not zero");
   result_capture_a: assert property (i_ce && i_conv.valid && !st_reg.frozen && !bus_start
      |=> st_reg.lux_result_high == {$past(i_conv.exponent), $past(i_conv.mantissa[7:4])})
      else $error("result high byte not captured");
   low_capture_a: assert property (i_ce && i_conv.valid && !st_reg.frozen && !bus_start
      |=> st_reg.lux_result_low == {4'h0, $past(i_conv.mantissa[3:0])})
      else $error("result low byte not captured");
   high_read_a: assert property (i_ce && i_reg_req.rd && i_reg_req.addr == ADDR_LUX_RESULT_HIGH
      |=> o_reg_rdata == $past(st_reg.lux_result_high))
      else $error("result high byte read back wrong");
   overrange_above_a: assert property (st_reg.live_exp == EXP_OVERRANGE
      |-> above_upper && !below_lower)
      else $error("overrange not treated as above");
   period_800_a: assert property (tim_eff == TIM_800 |-> o_integ_period_us == PERIOD_US_800)
      else $error("period decode wrong");
   divide_auto_a: assert property (i_ce && i_conv.valid && !st_reg.manual && i_conv.exponent == 4'h7
      && i_conv.mantissa == 8'hff |=> st_reg.cdr_auto)
      else $error("divider not chosen above 700 lux");
   auto_long_period_a: assert property (i_ce && i_conv.valid && !st_reg.manual
      && i_conv.exponent == 4'h0 |=> st_reg.tim_auto == TIM_800 && !st_reg.cdr_auto)
      else $error("dim light did not pick the longest period");
   auto_read_only_a: assert property (i_ce && i_reg_req.wr && i_reg_req.addr == ADDR_CONFIG
      && !st_reg.manual |=> $stable(st_reg.tim_user) && $stable(st_reg.cdr_user))
      else $error("range bits written in automatic ranging");
   manual_override_a: assert property (st_reg.manual
      |-> o_integ_period_sel == st_reg.tim_user && o_current_divide_sel == st_reg.cdr_user)
      else $error("user range bits not in effect");

   alert_set_c: cover property ($rose(st_reg.alert_status_bit));
   freeze_c: cover property ($rose(st_reg.frozen) ##[1:1000] $fell(st_reg.frozen));
   manual_c: cover property (st_reg.manual && tim_eff == TIM_6P25);
   clear_c: cover property ($fell(st_reg.alert_status_bit));
   rep_start_c: cover property (st_reg.frozen && bus_start);
endmodule
`default_nettype wire

// >>> bench/i2c_master_model.sv
// Bus master model that frames start, repeated start and stop on the bus pins.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
   output logic o_scl,
   output logic o_sda
);
   // Released lines sit at the pull-up level, and the clock stands high between frames.
   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // ---------------------------------------------
   // Framing
   // ---------------------------------------------
   // Works from idle and, with the clock low, as a repeated start; then one address byte.
   task automatic start(input logic [7:0] adr);
      logic [8:0] b;
      b = {adr, 1'b1};
      // A short lead keeps every pin change off the bench clock's edges.
      #3;
      o_sda = 1'b1;
      #40 o_scl = 1'b1;
      #80 o_sda = 1'b0;
      #80 o_scl = 1'b0;
      for (int i = 8; i >= 0; i--)
      begin
         #40 o_sda = b[i];
         #40 o_scl = 1'b1;
         #80 o_scl = 1'b0;
      end
   endtask
   task automatic stop();
      #3;
      #40 o_sda = 1'b0;
      #40 o_scl = 1'b1;
      #80 o_sda = 1'b1;
      #80;
   endtask
endmodule
`default_nettype wire

// >>> bench/test_lux_result_threshold_alert.sv
// Self-checking bench for the lux result and threshold alert block.
`timescale 1ns/1ps
`default_nettype none
module test_lux_result_threshold_alert;
   import lux_alert_pkg::*;
   localparam int PC = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   wire scl;
   wire sda;
   reg_req_t req = '0;
   conv_result_t conv = '0;
   logic [7:0] rdata;
   logic [2:0] sel;
   logic [19:0] per;
   logic current_divide_sel, cont, a_out, a_oe;
   int err_total = 0;
   int n_compared = 0;
   int per_us[8] = '{800000, 400000, 200000, 100000, 50000, 25000, 12500, 6250};
   logic [11:0] fx[8] = '{12'h0ff, 12'h4ff, 12'h580, 12'h680, 12'h780, 12'h7da, 12'h7db, 12'hf00};
   logic [7:0] tv[4] = '{8'h3f, 8'h40, 8'h10, 8'h0f};
   logic [3:0] te = 4'ha;
   int hi_m, lo_m, lc, esel, ecdr, cnt;
   logic frz = 1'b0;
   logic [11:0] code;
   // The alert line is open drain with a pull-up.
   wire alert_n = a_oe ? a_out : 1'b1;
   always #10 clk = ~clk;
   i2c_master_model i2c_master_model_inst (.o_scl(scl), .o_sda(sda));
   lux_result_threshold_alert #(.PERSIST_CYCLES(PC)) lux_result_threshold_alert_inst (
      .i_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_scl(scl), .i_sda(sda), .i_reg_req(req),
      .o_reg_rdata(rdata), .i_conv(conv), .o_integ_period_sel(sel), .o_integ_period_us(per),
      .o_current_divide_sel(current_divide_sel), .o_continuous(cont), .o_alert_n_out(a_out), .o_alert_n_oe(a_oe));
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= '0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      req <= '0;
      #1 check(rdata, exp);
   endtask
   // The model keeps the last unfrozen result and the counts that autoranging sees.
   task automatic cv(input logic [3:0] e, input logic [7:0] m);
      @(posedge clk);
      conv <= '{1'b1, e, m};
      @(posedge clk);
      conv <= '0;
      lc = (e == 4'hf) ? 32'h7fffffff : (int'(m) << e);
      if (!frz)
      begin
         hi_m = {e, m[7:4]};
         lo_m = m[3:0];
      end
   endtask
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      #500000;
      err_total++;
      end_sim();
   end
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   initial
   begin
      void'($urandom(52459));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      tick(1);
      rdc(ADDR_UPPER_TRIP_LEVEL, 8'hff);
      rdc(ADDR_LOWER_TRIP_LEVEL, 8'h00);
      rdc(ADDR_TRIP_PERSISTENCE_TIME, 8'hff);
      rdc(8'h08, 8'h00);
      rdc(ADDR_CONFIG, 8'h03);
      check(per, per_us[3]);
      // Written in automatic ranging, the range bits are ignored, so the user bits stay at zero.
      wr(ADDR_CONFIG, 8'h4f);
      rdc(ADDR_CONFIG, 8'h40);
      for (int c = 0; c < 16; c++)
      begin
         wr(ADDR_CONFIG, 8'h40 | 8'(c));
         rdc(ADDR_CONFIG, 8'h40 | 8'(c));
         check(sel, c % 8);
         check(per, per_us[c % 8]);
         check(current_divide_sel, c / 8);
      end
      cv(4'h0, 8'h01);
      tick(2);
      check(sel, 3'h7);
      wr(ADDR_CONFIG, 8'h80);
      wr(ADDR_LUX_RESULT_HIGH, 8'haa);
      for (int k = 0; k < 16; k++)
      begin
         code = (k < 8) ? fx[k] : {4'($urandom_range(14)), 8'($urandom)};
         cv(code[11:8], code[7:0]);
         tick(2);
         esel = lc < 4096 ? 0 : lc < 8192 ? 1 : lc < 16384 ? 2 : 3;
         ecdr = lc > 28000;
         check(sel, esel);
         check(per, per_us[esel]);
         check(current_divide_sel, ecdr);
         check(cont, 1'b1);
         rdc(ADDR_CONFIG, 8'(128 + ecdr * 8 + esel));
         rdc(ADDR_LUX_RESULT_HIGH, 8'(hi_m));
         rdc(ADDR_LUX_RESULT_LOW, 8'(lo_m));
      end
      cv(4'h1, 8'h11);
      frz = 1'b1;
      i2c_master_model_inst.start(8'hb5);
      cv(4'h2, 8'h22);
      rdc(ADDR_LUX_RESULT_HIGH, 8'(hi_m));
      i2c_master_model_inst.start(8'hb5);
      cv(4'h3, 8'h33);
      rdc(ADDR_LUX_RESULT_LOW, 8'(lo_m));
      i2c_master_model_inst.stop();
      frz = 1'b0;
      tick(5);
      cv(4'h4, 8'h45);
      rdc(ADDR_LUX_RESULT_LOW, 8'h05);
      wr(ADDR_TRIP_PERSISTENCE_TIME, 8'h00);
      wr(ADDR_LOWER_TRIP_LEVEL, 8'h01);
      wr(ADDR_UPPER_TRIP_LEVEL, 8'h03);
      cv(4'h0, 8'h40);
      tick(3);
      check(a_oe, 1'b0);
      cv(4'h0, 8'h28);
      wr(ADDR_ALERT_ENABLE, 8'h01);
      for (int k = 0; k < 4; k++)
      begin
         cv(4'h0, tv[k]);
         tick(2);
         check(alert_n, !te[k]);
         cv(4'h0, 8'h28);
         rdc(ADDR_ALERT_STATUS, 8'(te[k]));
         tick(1);
         check(alert_n, 1'b1);
      end
      wr(ADDR_TRIP_PERSISTENCE_TIME, 8'h02);
      cv(4'h0, 8'h05);
      tick(4);
      cv(4'h0, 8'h28);
      cv(4'h0, 8'h05);
      tick(5);
      check(a_oe, 1'b0);
      cnt = 0;
      while (a_oe !== 1'b1 && cnt < 20)
      begin
         tick(1);
         cnt++;
      end
      // Two steps of PC cycles after the capture edge, one more to register; five edges passed before the loop.
      check(cnt, 2 * PC - 4);
      wr(ADDR_ALERT_ENABLE, 8'h00);
      tick(1);
      check(a_oe, 1'b0);
      rdc(ADDR_ALERT_STATUS, 8'h00);
      end_sim();
   end
endmodule
`default_nettype wire
